// ### icc_clear_regs.sv
/*
 * Read-to-clear interrupt registers of the two-wire serial controller,
 * with the abort cause register, the transmit flush hold and the
 * controller enable bit.
 * Assumes the protocol engine delivers one-cycle event pulses and a
 * bus activity level, all synchronous to mclk, and a master on the
 * plain register port that never issues read and write together.
 */
`default_nettype none

// Function
// - A transmit-abort clear read clears the abort flag at bit 6 and the abort cause register.
// - That read also releases the transmit FIFO from its flushed state for new writes.
// - Bit 9 of the abort cause register may survive that clear while its exception holds.
// - Reading the receive-done clear register clears the receive-done flag at bit 7.
// - An activity clear read clears the activity flag at bit 8 only on an idle bus.
// - The activity flag clears by itself once the controller is disabled and the bus is idle.
// - Bit 0 read from the activity clear register shows the activity flag.
// - Reading the start-detect clear register clears the start flag at bit 10.
// - Reading the general-call clear register clears the general-call flag at bit 11.
// - Enable bit 0 turns the controller on, and while it is off both FIFOs are held erased.
module icc_clear_regs (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [31:0] busAddr,
    input wire logic [15:0] busWrData,
    input wire logic busWrite,
    input wire logic busRead,
    output var logic [15:0] busRdData,
    input wire logic abortEvent,
    input wire logic [15:0] abortCauseIn,
    input wire logic keepCauseBit,
    input wire logic rxDoneEvent,
    input wire logic busActive,
    input wire logic stopEvent,
    input wire logic startEvent,
    input wire logic genCallEvent,
    output var logic [15:0] rawIrqStatus,
    output var logic [15:0] abortCause,
    output var logic txFifoFlushed,
    output var logic controllerOn,
    output var logic fifoErase
);

    // ****************************************************************
    // Reset release.
    // ****************************************************************

    logic rstMeta;
    logic rstN;

    // The first stage feeds only the second, so release is metastability safe.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rstMeta <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstN <= rstMeta;
        end
    end

    // ****************************************************************
    // Address decode.
    // ****************************************************************

    // Exact word match; the same comparison serves reads and writes.
    function automatic logic hit(input logic [31:0] addr, input logic [31:0] reg_addr);
        hit = (addr == reg_addr);
    endfunction : hit

    wire logic rdAbort;
    wire logic rdRxDone;
    wire logic rdActivity;
    wire logic rdStop;
    wire logic rdStart;
    wire logic rdGenCall;
    wire logic rdEnable;
    wire logic wrEnable;

    // Read strobes per clear register; writes to them are simply not decoded.
    assign rdAbort = busRead && hit(busAddr, icc_pkg::TX_ABORT_CLEAR_ADDR);
    assign rdRxDone = busRead && hit(busAddr, icc_pkg::RX_DONE_CLEAR_ADDR);
    assign rdActivity = busRead && hit(busAddr, icc_pkg::BUS_ACTIVITY_CLEAR_ADDR);
    assign rdStop = busRead && hit(busAddr, icc_pkg::STOP_CONDITION_CLEAR_ADDR);
    assign rdStart = busRead && hit(busAddr, icc_pkg::START_CONDITION_CLEAR_ADDR);
    assign rdGenCall = busRead && hit(busAddr, icc_pkg::GENERAL_CALL_CLEAR_ADDR);
    assign rdEnable = busRead && hit(busAddr, icc_pkg::CONTROLLER_ENABLE_ADDR);
    assign wrEnable = busWrite && hit(busAddr, icc_pkg::CONTROLLER_ENABLE_ADDR);

    // ****************************************************************
    // Sticky flags.
    // ****************************************************************

    logic [icc_pkg::FLAG_N-1:0] flagSet;
    logic [icc_pkg::FLAG_N-1:0] flagClr;
    logic [icc_pkg::FLAG_N-1:0] flagQ;
    wire logic activityClr;

    // The activity flag follows the bus: a read clears it only on an idle
    // bus, and a disabled controller on an idle bus clears it unasked.
    assign activityClr = !busActive && (rdActivity || !controllerOn);

    // Set and clear terms, one slot per flag.
    assign flagSet = {genCallEvent, startEvent, stopEvent, busActive, rxDoneEvent, abortEvent};
    assign flagClr = {rdGenCall, rdStart, rdStop, activityClr, rdRxDone,
        rdAbort};

    // One identical cell per flag.
    genvar gi;
    generate
        for (gi = 0; gi < icc_pkg::FLAG_N; gi++) begin : gFlag
            icc_flag uFlag (
                .clk(mclk),
                .rstN(rstN),
                .set(flagSet[gi]),
                .clr(flagClr[gi]),
                .q(flagQ[gi])
            );
        end
    endgenerate

    wire logic abortFlag;
    wire logic rxDoneFlag;
    wire logic activityFlag;
    wire logic stopFlag;
    wire logic startFlag;
    wire logic genCallFlag;

    assign abortFlag = flagQ[0];
    assign rxDoneFlag = flagQ[1];
    assign activityFlag = flagQ[2];
    assign stopFlag = flagQ[3];
    assign startFlag = flagQ[4];
    assign genCallFlag = flagQ[5];

    // Raw status word; positions this block does not own read as zero.
    always_comb begin
        rawIrqStatus = 16'h0000;
        rawIrqStatus[icc_pkg::TX_ABORT_BIT] = abortFlag;
        rawIrqStatus[icc_pkg::RX_DONE_BIT] = rxDoneFlag;
        rawIrqStatus[icc_pkg::ACTIVITY_BIT] = activityFlag;
        rawIrqStatus[icc_pkg::STOP_BIT] = stopFlag;
        rawIrqStatus[icc_pkg::START_BIT] = startFlag;
        rawIrqStatus[icc_pkg::GENERAL_CALL_FLAG_BIT] = genCallFlag;
    end

    // ****************************************************************
    // Abort cause and transmit flush hold.
    // ****************************************************************

    logic [15:0] causeKeepMask;
    logic [15:0] next_abortCause;
    logic next_txFifoFlushed;

    // The exception bit is spared while its condition holds.
    always_comb begin
        causeKeepMask = 16'h0000;
        causeKeepMask[icc_pkg::CAUSE_KEEP_BIT] = keepCauseBit;
    end

    // New causes accumulate even in the clearing cycle, so none is lost.
    assign next_abortCause = (rdAbort ? (abortCause & causeKeepMask) : abortCause)
        | (abortEvent ? abortCauseIn : 16'h0000);

    // A fresh abort keeps the FIFO flushed even if the release read coincides.
    assign next_txFifoFlushed = abortEvent || (txFifoFlushed && !rdAbort);

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            abortCause <= icc_pkg::CAUSE_RESET;
            txFifoFlushed <= 1'b0;
        end else begin
            abortCause <= next_abortCause;
            txFifoFlushed <= next_txFifoFlushed;
        end
    end

    // ****************************************************************
    // Controller enable.
    // ****************************************************************

    logic next_controllerOn;

    assign next_controllerOn = wrEnable ? busWrData[icc_pkg::ENABLE_BIT] : controllerOn;

    // Erase follows the enable in the same edge, so the two never disagree.
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            controllerOn <= icc_pkg::ENABLE_RESET[icc_pkg::ENABLE_BIT];
            fifoErase <= !icc_pkg::ENABLE_RESET[icc_pkg::ENABLE_BIT];
        end else begin
            controllerOn <= next_controllerOn;
            fifoErase <= !next_controllerOn;
        end
    end

    // ****************************************************************
    // Read data.
    // ****************************************************************

    logic [15:0] next_busRdData;

    // Bit 0 shows the flag as it stood before this read cleared it.
    always_comb begin
        next_busRdData = icc_pkg::CLEAR_REG_RESET;
        unique case (1'b1)
            rdAbort: next_busRdData[0] = abortFlag;
            rdRxDone: next_busRdData[0] = rxDoneFlag;
            rdActivity: next_busRdData[0] = activityFlag;
            rdStop: next_busRdData[0] = stopFlag;
            rdStart: next_busRdData[0] = startFlag;
            rdGenCall: next_busRdData[0] = genCallFlag;
            rdEnable: next_busRdData[0] = controllerOn;
            default: next_busRdData = 16'h0000;
        endcase
    end

    // Data stand for the one cycle after the strobe and return to zero.
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            busRdData <= icc_pkg::CLEAR_REG_RESET;
        end else begin
            busRdData <= next_busRdData;
        end
    end

    // ****************************************************************
    // Assertions.
    // ****************************************************************

    property p_abortClear;
        @(posedge mclk) disable iff (!rstN)
        rdAbort && !abortEvent |=> !rawIrqStatus[icc_pkg::TX_ABORT_BIT];
    endproperty
    a_abortClear: assert property (p_abortClear) else $error("abort flag not cleared");

    property p_causeClear;
        @(posedge mclk) disable iff (!rstN)
        rdAbort && !abortEvent && !keepCauseBit |=> abortCause == 16'h0000;
    endproperty
    a_causeClear: assert property (p_causeClear) else $error("abort cause not cleared");

    property p_flushRelease;
        @(posedge mclk) disable iff (!rstN)
        txFifoFlushed && rdAbort && !abortEvent
        |=> !txFifoFlushed ##1 (!txFifoFlushed || $past(abortEvent));
    endproperty
    a_flushRelease: assert property (p_flushRelease) else $error("flush not released");

    property p_causeKeep;
        @(posedge mclk) disable iff (!rstN)
        rdAbort && keepCauseBit && abortCause[icc_pkg::CAUSE_KEEP_BIT]
        |=> abortCause[icc_pkg::CAUSE_KEEP_BIT];
    endproperty
    a_causeKeep: assert property (p_causeKeep) else $error("kept cause bit lost");

    property p_rxDoneClear;
        @(posedge mclk) disable iff (!rstN)
        rdRxDone && !rxDoneEvent |=> !rawIrqStatus[icc_pkg::RX_DONE_BIT];
    endproperty
    a_rxDoneClear: assert property (p_rxDoneClear) else $error("rx done not cleared");

    property p_activityHold;
        @(posedge mclk) disable iff (!rstN)
        busActive |=> rawIrqStatus[icc_pkg::ACTIVITY_BIT];
    endproperty
    a_activityHold: assert property (p_activityHold) else $error("activity dropped");

    property p_activityAuto;
        @(posedge mclk) disable iff (!rstN)
        !controllerOn && !busActive |=> !rawIrqStatus[icc_pkg::ACTIVITY_BIT];
    endproperty
    a_activityAuto: assert property (p_activityAuto) else $error("activity stuck");

    property p_activityRead;
        @(posedge mclk) disable iff (!rstN)
        rdActivity |=> busRdData[0] == $past(rawIrqStatus[icc_pkg::ACTIVITY_BIT]);
    endproperty
    a_activityRead: assert property (p_activityRead) else $error("activity read wrong");

    property p_startClear;
        @(posedge mclk) disable iff (!rstN)
        rdStart && !startEvent |=> !rawIrqStatus[icc_pkg::START_BIT];
    endproperty
    a_startClear: assert property (p_startClear) else $error("start flag not cleared");

    property p_genCallClear;
        @(posedge mclk) disable iff (!rstN)
        rdGenCall && !genCallEvent |=> !rawIrqStatus[icc_pkg::GENERAL_CALL_FLAG_BIT];
    endproperty
    a_genCallClear: assert property (p_genCallClear) else $error("general_call_flag stuck");

    property p_stopClear;
        @(posedge mclk) disable iff (!rstN)
        rdStop && !stopEvent |=> !rawIrqStatus[icc_pkg::STOP_BIT];
    endproperty
    a_stopClear: assert property (p_stopClear) else $error("stop flag not cleared");

    property p_upperZero;
        @(posedge mclk) disable iff (!rstN)
        busRead |=> busRdData[15:1] == 15'h0000 ##1 busRdData == 16'h0000 || $past(busRead);
    endproperty
    a_upperZero: assert property (p_upperZero) else $error("read data upper bits set");

    property p_eraseOff;
        @(posedge mclk) disable iff (!rstN)
        wrEnable && !busWrData[icc_pkg::ENABLE_BIT] |=> fifoErase && !controllerOn;
    endproperty
    a_eraseOff: assert property (p_eraseOff) else $error("fifos not erased when off");

endmodule : icc_clear_regs

`default_nettype wire

// ### icc_pkg.sv
/*
 * Shared constants for the read-to-clear interrupt register block of the
 * two-wire serial controller: register byte addresses, flag positions and
 * reset values.
 * Assumes a 32-bit byte address and 16-bit register data on the plain port.
 */
`default_nettype none

package icc_pkg;

    // ****************************************************************
    // Bus widths.
    // ****************************************************************
    localparam int ADDR_W = 32;
    localparam int DATA_W = 16;

    // ****************************************************************
    // Register byte addresses.
    // ****************************************************************
    localparam logic [31:0] TX_ABORT_CLEAR_ADDR = 32'h5000_1354;
    localparam logic [31:0] RX_DONE_CLEAR_ADDR = 32'h5000_1358;
    localparam logic [31:0] BUS_ACTIVITY_CLEAR_ADDR = 32'h5000_135c;
    localparam logic [31:0] STOP_CONDITION_CLEAR_ADDR = 32'h5000_1360;
    localparam logic [31:0] START_CONDITION_CLEAR_ADDR = 32'h5000_1364;
    localparam logic [31:0] GENERAL_CALL_CLEAR_ADDR = 32'h5000_1368;
    localparam logic [31:0] CONTROLLER_ENABLE_ADDR = 32'h5000_136c;

    // ****************************************************************
    // Flag positions in the raw interrupt status word.
    // ****************************************************************
    localparam int TX_ABORT_BIT = 6;
    localparam int RX_DONE_BIT = 7;
    localparam int ACTIVITY_BIT = 8;
    localparam int STOP_BIT = 9;
    localparam int START_BIT = 10;
    localparam int GENERAL_CALL_FLAG_BIT = 11;

    // Position in the abort cause register that may survive a clear.
    localparam int CAUSE_KEEP_BIT = 9;

    // Enable bit position in the controller enable register.
    localparam int ENABLE_BIT = 0;

    // Number of sticky flags kept by this block.
    localparam int FLAG_N = 6;

    // ****************************************************************
    // Reset values.
    // ****************************************************************
    localparam logic [15:0] CLEAR_REG_RESET = 16'h0000;
    localparam logic [15:0] ENABLE_RESET = 16'h0000;
    localparam logic [15:0] CAUSE_RESET = 16'h0000;
    localparam logic FLAG_RESET = 1'b0;

endpackage : icc_pkg

`default_nettype wire

// ### icc_flag.sv
/*
 * One sticky flag: set by a hardware event, cleared by a clear request.
 * Assumes set and clear are synchronous to the clock; the reset is the
 * already synchronised active-low copy.
 */
`default_nettype none

module icc_flag (
    input wire logic clk,
    input wire logic rstN,
    input wire logic set,
    input wire logic clr,
    output var logic q
);

    // Set wins over clear so an event in the clearing cycle is not lost.
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            q <= icc_pkg::FLAG_RESET;
        end else if (set) begin
            q <= 1'b1;
        end else if (clr) begin
            q <= 1'b0;
        end
    end

endmodule : icc_flag

`default_nettype wire

// ### icc_engine_model.sv
/*
 * Model of the protocol engine that faces the clear registers: it turns
 * one-cycle requests from the bench into event pulses, an activity level
 * and abort cause bits.
 * Assumes requests change just after a rising edge of mclk.
 */
`default_nettype none

module icc_engine_model (
    input wire logic mclk,
    input wire logic [5:0] fireReq,
    input wire logic activeReq,
    input wire logic [15:0] causeReq,
    output logic [5:0] events,
    output logic active,
    output logic [15:0] cause
);
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************************************
    // Event outputs.
    // ****************************************************************
    initial begin
        events = 6'h00;
        active = 1'b0;
        cause = 16'h0000;
    end

    // Cause bits are only meaningful beside an abort pulse, so between
    // pulses they toggle to keep the design from leaning on stale values.
    always @(posedge mclk) begin
        events <= fireReq;
        active <= activeReq;
        cause <= fireReq[0] ? causeReq : ~cause;
    end

endmodule : icc_engine_model

`default_nettype wire

// ### i2c_interrupt_clear_regs_bench.sv
/*
 * Self-checking bench for the read-to-clear register block: a cycle model
 * is compared with every output on every falling edge while nrst is high.
 * Assumes the engine model beside it and the shared package.
 */
`default_nettype none

module i2c_interrupt_clear_regs_bench;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [31:0] ADDRS [8] = '{icc_pkg::TX_ABORT_CLEAR_ADDR,
        icc_pkg::RX_DONE_CLEAR_ADDR, icc_pkg::BUS_ACTIVITY_CLEAR_ADDR,
        icc_pkg::STOP_CONDITION_CLEAR_ADDR, icc_pkg::START_CONDITION_CLEAR_ADDR,
        icc_pkg::GENERAL_CALL_CLEAR_ADDR, icc_pkg::CONTROLLER_ENABLE_ADDR, 32'h5000_1350};

    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [31:0] busAddr = 32'h0000_0000;
    logic [15:0] busWrData = 16'h0000;
    logic busWrite = 1'b0;
    logic busRead = 1'b0;
    logic [5:0] fireReq = 6'h00;
    logic activeReq = 1'b0;
    logic [15:0] causeReq = 16'hffff;
    logic keepCauseBit = 1'b0;
    wire logic [5:0] events;
    wire logic active;
    wire logic [15:0] cause;
    logic [15:0] busRdData, rawIrqStatus, abortCause;
    logic txFifoFlushed, controllerOn, fifoErase;
    logic [1:0] mSync;
    logic [5:0] mFlag, evs;
    logic [15:0] mCause, mRd;
    logic mFlush, mOn, hit;
    logic [31:0] r;
    int miscompares = 0;
    int checksDone = 0;
    int cycles = 0;
    wire logic [50:0] gotWord;
    wire logic [50:0] expWord;

    // ****************************************************************
    // Design, engine model and reference model.
    // ****************************************************************
    icc_clear_regs DUT (.mclk(mclk), .nrst(nrst), .busAddr(busAddr), .busWrData(busWrData),
        .busWrite(busWrite), .busRead(busRead), .busRdData(busRdData),
        .abortEvent(events[0]), .abortCauseIn(cause), .keepCauseBit(keepCauseBit),
        .rxDoneEvent(events[1]), .busActive(active), .stopEvent(events[3]),
        .startEvent(events[4]), .genCallEvent(events[5]), .rawIrqStatus(rawIrqStatus),
        .abortCause(abortCause), .txFifoFlushed(txFifoFlushed),
        .controllerOn(controllerOn), .fifoErase(fifoErase));

    icc_engine_model engine (.mclk(mclk), .fireReq(fireReq), .activeReq(activeReq),
        .causeReq(causeReq), .events(events), .active(active), .cause(cause));

    initial begin
        forever #20 mclk = ~mclk;
    end

    // Reference state advances like the design, including the two-stage
    // reset release, so that every cycle can be compared.
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            mSync = 2'b00;
            mFlag = 6'h00;
            mCause = 16'h0000;
            mRd = 16'h0000;
            mFlush = 1'b0;
            mOn = 1'b0;
        end else begin
            if (mSync[1]) begin
                evs = {events[5:3], active, events[1:0]};
                mRd = 16'h0000;
                for (int i = 0; i < 6; i++) begin
                    hit = busRead && (busAddr === ADDRS[i]);
                    if (hit) mRd = {15'h0000, mFlag[i]};
                    if (i == 2) hit = (hit || !mOn) && !active;
                    if (evs[i]) mFlag[i] = 1'b1;
                    else if (hit) mFlag[i] = 1'b0;
                end
                if (busRead && busAddr === ADDRS[6]) mRd = {15'h0000, mOn};
                // The clear read acts first; a new abort in that cycle still lands.
                if (busRead && busAddr === ADDRS[0]) begin
                    mCause = mCause & (16'h0001 << icc_pkg::CAUSE_KEEP_BIT);
                    if (!keepCauseBit) mCause = 16'h0000;
                    mFlush = 1'b0;
                end
                if (events[0]) begin
                    mCause = mCause | cause;
                    mFlush = 1'b1;
                end
                if (busWrite && busAddr === ADDRS[6]) mOn = busWrData[0];
            end
            mSync = {mSync[0], 1'b1};
        end
    end

    // ****************************************************************
    // Checking, bus cycles and stimulus.
    // ****************************************************************
    assign gotWord = {rawIrqStatus, abortCause, busRdData, txFifoFlushed, controllerOn, fifoErase};
    assign expWord = {4'h0, mFlag, 6'h00, mCause, mRd, mFlush, mOn, !mOn};

    task automatic check(input logic [50:0] got, input logic [50:0] exp);
        checksDone++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic finishTest();
        $display("checks %0d mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finishTest

    // One bus cycle; strobes persist until the next call, which keeps
    // back-to-back accesses legal without a second assignment per step.
    task automatic op(input logic rd, input logic wr, input logic [31:0] a,
                      input logic [15:0] d = 16'h0000, input logic [5:0] f = 6'h00);
        busRead <= rd;
        busWrite <= wr;
        busAddr <= a;
        busWrData <= d;
        fireReq <= f;
        @(posedge mclk);
    endtask : op

    // Outputs are settled at the falling edge, away from launch edges.
    always @(negedge mclk) begin
        if (nrst === 1'b1) begin
            check(gotWord, expWord);
        end
    end

    // The run needs about 580 cycles; the ceiling leaves ample margin.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 4000) begin
            miscompares++;
            finishTest();
        end
    end

    initial begin
        void'($urandom(82202));
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        for (int i = 0; i < 8; i++) op(1'b1, 1'b0, ADDRS[i]);
        for (int i = 0; i < 8; i++) op(1'b0, 1'b1, ADDRS[i], 16'hffff);
        for (int i = 0; i < 8; i++) op(1'b1, 1'b0, ADDRS[i]);
        // Each source fires, then three reads in a row; activity drops late.
        for (int i = 0; i < 6; i++) begin
            activeReq <= (i == 2);
            op(1'b0, 1'b0, ADDRS[7], 16'h0000, 6'h01 << i);
            activeReq <= 1'b0;
            repeat (3) op(1'b1, 1'b0, ADDRS[i]);
        end
        // Abort cause with and without the kept bit, each with set beside clear.
        keepCauseBit <= 1'b1;
        op(1'b0, 1'b0, ADDRS[7], 16'h0000, 6'h01);
        op(1'b1, 1'b0, ADDRS[0]);
        op(1'b1, 1'b0, ADDRS[0]);
        keepCauseBit <= 1'b0;
        op(1'b0, 1'b0, ADDRS[7], 16'h0000, 6'h01);
        op(1'b1, 1'b0, ADDRS[0]);
        op(1'b1, 1'b0, ADDRS[0]);
        op(1'b1, 1'b0, ADDRS[0]);
        // Disable while active: the flag holds, then drops by itself.
        activeReq <= 1'b1;
        op(1'b0, 1'b1, ADDRS[6], 16'h0000);
        activeReq <= 1'b0;
        repeat (4) op(1'b0, 1'b0, ADDRS[7]);
        op(1'b0, 1'b1, ADDRS[6], 16'h0001);
        // Reset in mid-run with every flag but the activity flag set.
        op(1'b0, 1'b0, ADDRS[7], 16'h0000, 6'h3f);
        op(1'b0, 1'b0, ADDRS[7]);
        nrst <= 1'b0;
        op(1'b0, 1'b0, ADDRS[7]);
        nrst <= 1'b1;
        repeat (3) op(1'b0, 1'b0, ADDRS[7]);
        for (int n = 0; n < 500; n++) begin
            r = $urandom;
            activeReq <= r[0] & r[1];
            keepCauseBit <= r[2];
            causeReq <= 16'($urandom);
            op(r[4], !r[4] & r[3], ADDRS[r[7:5]], 16'(r[23:8]), 6'(r[29:24] & r[14:9]));
        end
        repeat (2) op(1'b0, 1'b0, ADDRS[7]);
        finishTest();
    end

endmodule : i2c_interrupt_clear_regs_bench

`default_nettype wire
